// ==== hdl/ctb_accept_cmp.sv ====
// identifier acceptance compare against one 32-bit code and mask bank
`timescale 1ns/10ps
module ctb_accept_cmp (
  input wire logic [31:0] rx_id,
  input wire logic [31:0] accept_code,
  input wire logic [31:0] accept_mask_bit,
  output logic hit
);
  logic [31:0] bit_ok;

  // a set mask bit is don't care, a clear one demands equality
  genvar i;
  generate
    for (i = 0; i < 32; i++) begin : g_bit
      assign bit_ok[i] = accept_mask_bit[i] | (rx_id[i] == accept_code[i]); // see [RQ1] [RQ3]
    end
  endgenerate

  // all compared bits must agree before the message is taken
  assign hit = &bit_ok; // see [RQ2]
endmodule : ctb_accept_cmp

// ==== hdl/ctb_pkg.sv ====
// constants, register map and state layout for the can transmit buffer block
package ctb_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] CTB_OFF_CTRL = 8'h00;
  localparam logic [7:0] CTB_OFF_TXFLG = 8'h04;
  localparam logic [7:0] CTB_OFF_TBSEL = 8'h08;
  localparam logic [7:0] CTB_OFF_TIMER = 8'h0c;
  localparam logic [7:0] CTB_OFF_MASK = 8'h10;
  localparam logic [7:0] CTB_OFF_CODE = 8'h20;
  localparam logic [7:0] CTB_OFF_WIN = 8'h40;
  // control register bit positions
  localparam int CTB_CTRL_INIT_REQUEST = 0;
  localparam int CTB_CTRL_INIT_ACK = 1;
  localparam int CTB_CTRL_TSEN = 2;
  // message buffer layout, one byte per word in the window
  localparam int CTB_NUM_TXBUF = 3;
  localparam int CTB_BUF_BYTES = 16;
  localparam int CTB_MSG_BYTES = 13;
  localparam logic [3:0] CTB_LOCAL_PRIORITY_BYTE = 4'hd;
  localparam logic [3:0] CTB_STAMP_HI = 4'he;
  localparam logic [3:0] CTB_STAMP_LO = 4'hf;
  // reset values
  localparam logic [2:0] CTB_EMPTY_RST = 3'h7;
  localparam logic [2:0] CTB_SEL_RST = 3'h0;
  localparam logic [7:0] CTB_MASK_RST = 8'h00;
  localparam logic [7:0] CTB_CODE_RST = 8'h00;
  localparam logic [15:0] CTB_TIMER_RST = 16'h0000;
  // bit clock for the stamping timer, derived from pclk
  localparam int CTB_CLK_NS = 20;
  localparam int CTB_BIT_NS = 1000;
  localparam logic [7:0] CTB_BIT_DIV = 8'((CTB_BIT_NS + CTB_CLK_NS - 1) / CTB_CLK_NS);

  // whole block state, registered in one process
  typedef struct packed {
    logic init_req;
    logic init_ack;
    logic ts_en;
    logic [2:0] empty;
    logic [2:0] sel;
    logic [15:0] timer;
    logic [7:0] div_cnt;
    logic [3:0][7:0] mask;
    logic [3:0][7:0] code;
    logic [2:0][15:0][7:0] bufm;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic filter_hit;
    logic [2:0] pending;
    logic [1:0] pick;
    logic pick_valid;
    logic [7:0] eng_data;
  } ctb_state_t;
endpackage : ctb_pkg

// ==== hdl/ctb_top.sv ====
// can transmit buffers, time stamp timer and second mask bank behind apb
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/10ps
//
// Operation
// [RQ1] a clear mask bit requires identifier bit to equal acceptance code bit
// [RQ2] message accepted only when all unmasked identifier bits match the code
// [RQ3] a set mask bit makes the code bit don't care
// [RQ4] mask registers always readable, writable only when init request and ack are one
// [RQ5] each buffer spans 16 byte slots holding a 13 byte message
// [RQ6] after success a 16-bit timer stamp lands in the last two bytes
// [RQ7] stamping only while the timestamp enable bit is set
// [RQ8] stamp bytes are written by hardware only, cpu writes have no effect
// [RQ9] stamp timer counts on the bit clock and wraps silently
// [RQ10] stamp timer held at zero in initialization mode
// [RQ11] cpu reads a transmit stamp only when empty and selected
// [RQ12] three independent transmit buffers for back to back sending
// [RQ13] each transmit buffer has an 8-bit local priority byte
// [RQ14] among ready buffers the local priority picks the one to send
// [RQ15] cpu finds an empty buffer then writes the selection register
// [RQ16] the selected buffer appears in the single transmit window
// [RQ17] cpu loads the buffer then clears its empty flag to schedule
// [RQ18] empty flag set after successful send or successful abort
// [RQ19] cpu access blocked while the buffer is scheduled
// [RQ20] writing one clears an empty flag, zero ignored, only outside init mode
// [RQ21] mask writes outside initialization mode are discarded
module ctb_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] rx_id,
  input wire logic rx_id_valid,
  output logic filter_hit,
  input wire logic tx_done,
  input wire logic [1:0] tx_done_idx,
  input wire logic tx_abort_ok,
  input wire logic [1:0] tx_abort_idx,
  input wire logic [1:0] eng_buf_idx,
  input wire logic [3:0] eng_byte_idx,
  output logic [7:0] eng_data,
  output logic [2:0] tx_pending,
  output logic [1:0] tx_pick,
  output logic tx_pick_valid,
  output logic init_ack
);
  ctb_pkg::ctb_state_t st_reg;
  ctb_pkg::ctb_state_t st_next;
  logic id_hit;
  logic init_mode;
  logic bus_wr;
  logic in_win;
  logic win_blocked;
  logic [1:0] sel_idx;
  logic [3:0] win_byte;
  logic [1:0] mask_idx;

  // lowest set bit of a vector, as a one-hot value
  function automatic logic [2:0] ctb_lowest(input logic [2:0] v);
    logic [2:0] r;
    r = 3'h0;
    if (v[0]) begin
      r = 3'h1;
    end else if (v[1]) begin
      r = 3'h2;
    end else if (v[2]) begin
      r = 3'h4;
    end
    return r;
  endfunction : ctb_lowest

  // one-hot to index, zero maps to index zero
  function automatic logic [1:0] ctb_index(input logic [2:0] v);
    logic [1:0] r;
    r = 2'h0;
    if (v[1]) begin
      r = 2'h1;
    end else if (v[2]) begin
      r = 2'h2;
    end
    return r;
  endfunction : ctb_index

  // filter compare on the second bank
  ctb_accept_cmp u_cmp (
    .rx_id(rx_id),
    .accept_code(st_reg.code),
    .accept_mask_bit(st_reg.mask),
    .hit(id_hit)
  );

  // shared decode of the current bus address
  always_comb begin
    init_mode = st_reg.init_req & st_reg.init_ack;
    bus_wr = psel & penable & st_reg.pready & pwrite;
    in_win = (paddr[7:6] == ctb_pkg::CTB_OFF_WIN[7:6]);
    win_byte = paddr[5:2];
    mask_idx = paddr[3:2];
    sel_idx = ctb_index(st_reg.sel);
    // no selection, or the selection is scheduled: window locked
    win_blocked = (st_reg.sel == 3'h0) || ((st_reg.sel & st_reg.empty) == 3'h0); // see [RQ19]
  end

  // next state of the whole block
  always_comb begin
    logic [7:0] best_local_priority;
    logic [1:0] best_idx;
    logic found;
    logic [2:0] set_empty;
    logic [2:0] clr_empty;
    best_local_priority = 8'hff;
    best_idx = 2'h0;
    found = 1'b0;
    set_empty = 3'h0;
    clr_empty = 3'h0;
    st_next = st_reg;

    // the init acknowledge follows the request one cycle later
    st_next.init_ack = st_reg.init_req;

    // bit clock enable and free running stamp timer
    if (init_mode) begin
      st_next.timer = ctb_pkg::CTB_TIMER_RST; // see [RQ10]
      st_next.div_cnt = 8'h00;
    end else if (st_reg.div_cnt == ctb_pkg::CTB_BIT_DIV - 8'h01) begin
      st_next.div_cnt = 8'h00;
      st_next.timer = st_reg.timer + 16'h0001; // see [RQ9]
    end else begin
      st_next.div_cnt = st_reg.div_cnt + 8'h01;
    end

    // engine completions, stamp written into the last two bytes
    if (tx_done && tx_done_idx < 2'h3) begin
      set_empty[tx_done_idx] = 1'b1; // see [RQ18]
      if (st_reg.ts_en) begin // see [RQ7]
        st_next.bufm[tx_done_idx][ctb_pkg::CTB_STAMP_HI] = st_reg.timer[15:8]; // see [RQ6]
        st_next.bufm[tx_done_idx][ctb_pkg::CTB_STAMP_LO] = st_reg.timer[7:0];
      end
    end
    if (tx_abort_ok && tx_abort_idx < 2'h3) begin
      set_empty[tx_abort_idx] = 1'b1; // see [RQ18]
    end

    // apb setup cycle: prepare answer so access phase ends in one cycle
    // the answer stands for the access cycle only, then falls back to zero
    st_next.pready = psel & ~penable;
    st_next.prdata = 32'h0;
    st_next.pslverr = 1'b0;
    if (psel && !penable) begin
      if (paddr[1:0] != 2'h0) begin
        st_next.pslverr = 1'b1;
      end else if (paddr == ctb_pkg::CTB_OFF_CTRL) begin
        st_next.prdata[ctb_pkg::CTB_CTRL_INIT_REQUEST] = st_reg.init_req;
        st_next.prdata[ctb_pkg::CTB_CTRL_INIT_ACK] = st_reg.init_ack;
        st_next.prdata[ctb_pkg::CTB_CTRL_TSEN] = st_reg.ts_en;
      end else if (paddr == ctb_pkg::CTB_OFF_TXFLG) begin
        st_next.prdata[2:0] = st_reg.empty;
      end else if (paddr == ctb_pkg::CTB_OFF_TBSEL) begin
        st_next.prdata[2:0] = st_reg.sel;
      end else if (paddr == ctb_pkg::CTB_OFF_TIMER) begin
        st_next.prdata[15:0] = st_reg.timer;
      end else if (paddr[7:4] == ctb_pkg::CTB_OFF_MASK[7:4]) begin
        st_next.prdata[7:0] = st_reg.mask[mask_idx]; // see [RQ4]
      end else if (paddr[7:4] == ctb_pkg::CTB_OFF_CODE[7:4]) begin
        st_next.prdata[7:0] = st_reg.code[mask_idx];
      end else if (in_win) begin
        // stamp is only readable once empty and selected, like all bytes
        if (win_blocked) begin
          st_next.pslverr = 1'b1; // see [RQ11] [RQ19]
        end else begin
          st_next.prdata[7:0] = st_reg.bufm[sel_idx][win_byte]; // see [RQ16]
        end
      end else begin
        st_next.pslverr = 1'b1;
      end
    end

    // apb write, taken on the access edge only
    if (bus_wr && paddr[1:0] == 2'h0) begin
      if (paddr == ctb_pkg::CTB_OFF_CTRL) begin
        st_next.init_req = pwdata[ctb_pkg::CTB_CTRL_INIT_REQUEST];
        st_next.ts_en = pwdata[ctb_pkg::CTB_CTRL_TSEN];
      end else if (paddr == ctb_pkg::CTB_OFF_TXFLG) begin
        if (!init_mode) begin
          clr_empty = pwdata[2:0]; // see [RQ20] [RQ17]
        end
      end else if (paddr == ctb_pkg::CTB_OFF_TBSEL) begin
        // lowest requested buffer that is still empty wins the pointer
        if (!init_mode) begin
          st_next.sel = ctb_lowest(pwdata[2:0] & st_reg.empty); // see [RQ15] [RQ16]
        end
      end else if (paddr[7:4] == ctb_pkg::CTB_OFF_MASK[7:4]) begin
        if (init_mode) begin
          st_next.mask[mask_idx] = pwdata[7:0]; // see [RQ4] [RQ21]
        end
      end else if (paddr[7:4] == ctb_pkg::CTB_OFF_CODE[7:4]) begin
        if (init_mode) begin
          st_next.code[mask_idx] = pwdata[7:0];
        end
      end else if (in_win) begin
        // stamp slots sit above the priority byte and ignore the cpu
        if (!win_blocked && win_byte <= ctb_pkg::CTB_LOCAL_PRIORITY_BYTE) begin // see [RQ8] [RQ19]
          st_next.bufm[sel_idx][win_byte] = pwdata[7:0]; // see [RQ5] [RQ13]
        end
      end
    end

    // hardware set wins over a same-cycle cpu clear
    st_next.empty = (st_reg.empty & ~clr_empty) | set_empty; // see [RQ18]
    if (init_mode) begin
      st_next.empty = ctb_pkg::CTB_EMPTY_RST;
      st_next.sel = ctb_pkg::CTB_SEL_RST;
    end else if ((st_reg.sel & ~st_next.empty) != 3'h0) begin
      // a scheduled buffer drops out of the window
      st_next.sel = 3'h0;
    end

    // local priority arbitration, lower value first, lower index on tie
    for (int b = 0; b < ctb_pkg::CTB_NUM_TXBUF; b++) begin
      if (!st_reg.empty[b] && (!found || st_reg.bufm[b][ctb_pkg::CTB_LOCAL_PRIORITY_BYTE] < best_local_priority)) begin
        found = 1'b1;
        best_local_priority = st_reg.bufm[b][ctb_pkg::CTB_LOCAL_PRIORITY_BYTE]; // see [RQ14]
        best_idx = 2'(b);
      end
    end
    st_next.pending = init_mode ? 3'h0 : ~st_reg.empty; // see [RQ12]
    st_next.pick = best_idx;
    st_next.pick_valid = found & ~init_mode;

    // engine read port for the message bytes
    st_next.eng_data = (eng_buf_idx < 2'h3) ? st_reg.bufm[eng_buf_idx][eng_byte_idx] : 8'h00;

    // filter hit pulse for each presented identifier that matches
    st_next.filter_hit = rx_id_valid & id_hit; // see [RQ2]
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
      st_reg.empty <= ctb_pkg::CTB_EMPTY_RST;
      st_reg.sel <= ctb_pkg::CTB_SEL_RST;
      st_reg.mask <= {4{ctb_pkg::CTB_MASK_RST}};
      st_reg.code <= {4{ctb_pkg::CTB_CODE_RST}};
      st_reg.timer <= ctb_pkg::CTB_TIMER_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign filter_hit = st_reg.filter_hit;
  assign eng_data = st_reg.eng_data;
  assign tx_pending = st_reg.pending;
  assign tx_pick = st_reg.pick;
  assign tx_pick_valid = st_reg.pick_valid;
  assign init_ack = st_reg.init_ack;
endmodule : ctb_top

// ==== verification/ctb_engine_model.sv ====
// protocol engine model that sends the picked transmit buffer
`timescale 1ns/10ps
module ctb_engine_model #(parameter int DLY = 60) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic [1:0] tx_pick,
  input wire logic tx_pick_valid,
  output logic tx_done,
  output logic [1:0] tx_done_idx,
  output logic [1:0] eng_buf_idx,
  output logic [3:0] eng_byte_idx
);
  int cnt;
  logic [1:0] cur;
  assign eng_buf_idx = cur;
  assign eng_byte_idx = 4'h0;
  // frame time is a plain wait; idle cycles after the pulse let pending settle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      cur <= 2'h0;
      tx_done <= 1'b0;
      tx_done_idx <= 2'h0;
    end else begin
      tx_done <= 1'b0;
      tx_done_idx <= ~tx_done_idx; // index is meaningless outside the pulse
      if (cnt == 0 && go && tx_pick_valid) begin
        cur <= tx_pick;
        cnt <= DLY;
      end else if (cnt == 6) begin
        tx_done <= 1'b1;
        tx_done_idx <= cur;
        cnt <= cnt - 1;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : ctb_engine_model

// ==== verification/ctb_top_assertions.sv ====
// port-level assertions for the can transmit buffer block
`timescale 1ns/10ps
module ctb_top_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rx_id_valid,
  input wire logic filter_hit,
  input wire logic tx_done,
  input wire logic [1:0] tx_done_idx,
  input wire logic [2:0] tx_pending,
  input wire logic [1:0] tx_pick,
  input wire logic tx_pick_valid,
  input wire logic init_ack
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb phases as named steps
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence bad_setup;
    psel && !penable && paddr[1:0] != 2'h0;
  endsequence
  ready_after_setup_a: assert property (apb_setup |=> pready)
    else $error("no ready after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  misaligned_err_a: assert property (bad_setup |=> pslverr)
    else $error("misaligned access not refused");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  refused_zero_a: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused read returns data");
  hit_cause_a: assert property (filter_hit |-> $past(rx_id_valid))
    else $error("filter hit without identifier");
  done_sets_empty_a: assert property ((tx_done && tx_done_idx != 2'h3)
    |-> ##2 !tx_pending[$past(tx_done_idx, 2)])
    else $error("sent buffer still pending");
  idle_no_pick_a: assert property ((tx_pending == 3'h0) [*2] |-> !tx_pick_valid)
    else $error("pick with nothing pending");
  pick_pending_a: assert property (tx_pick_valid |-> tx_pending[tx_pick])
    else $error("picked buffer not pending");
  init_clears_a: assert property (init_ack [*4] |-> tx_pending == 3'h0)
    else $error("pending in init mode");
endmodule : ctb_top_assertions
bind ctb_top ctb_top_assertions u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .rx_id_valid, .filter_hit, .tx_done, .tx_done_idx, .tx_pending,
  .tx_pick, .tx_pick_valid, .init_ack);

// ==== verification/tb.sv ====
// self-checking bench for the can transmit buffer block
`timescale 1ns/10ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic rx_id_valid = 1'b0;
  logic abort_ok = 1'b0;
  logic [1:0] abort_idx = 2'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rx_id = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, filter_hit, tx_pick_valid, init_ack, tx_done, err;
  logic [1:0] tx_done_idx, tx_pick, eng_buf_idx;
  logic [3:0] eng_byte_idx;
  logic [7:0] eng_data;
  logic [2:0] tx_pending;
  int err_total = 0;
  int total_checks = 0;
  initial begin
    forever #10 pclk = ~pclk;
  end
  ctb_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rx_id, .rx_id_valid, .filter_hit, .tx_done, .tx_done_idx, .tx_abort_ok(abort_ok),
    .tx_abort_idx(abort_idx), .eng_buf_idx, .eng_byte_idx, .eng_data, .tx_pending, .tx_pick,
    .tx_pick_valid, .init_ack);
  ctb_engine_model #(.DLY(60)) u_eng (.pclk, .presetn, .go, .tx_pick, .tx_pick_valid,
    .tx_done, .tx_done_idx, .eng_buf_idx, .eng_byte_idx);
  // verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer; an idle edge first so no signal is driven twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      err_total++;
      summarize();
    end
  endtask : apb
  // pulse an identifier into the filter, judge the registered hit
  task automatic hit(input logic [31:0] id, input logic exp);
    @(posedge pclk);
    rx_id <= id;
    rx_id_valid <= 1'b1;
    @(posedge pclk);
    rx_id_valid <= 1'b0;
    @(posedge pclk);
    chk(32'(filter_hit), 32'(exp));
  endtask : hit
  task automatic t_reset;
    apb(1'b1, ctb_pkg::CTB_OFF_TXFLG, 32'h0);
    apb(1'b0, ctb_pkg::CTB_OFF_TXFLG, 32'h0);
    chk(rd, 32'h7);
    apb(1'b0, ctb_pkg::CTB_OFF_MASK, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h02, 32'h0);
    chk(32'(err), 32'h1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_filter;
    apb(1'b1, ctb_pkg::CTB_OFF_CTRL, 32'h1);
    apb(1'b1, ctb_pkg::CTB_OFF_MASK, 32'h0f);
    for (int i = 1; i < 4; i++) apb(1'b1, ctb_pkg::CTB_OFF_MASK + 8'(4 * i), 32'hff);
    apb(1'b1, ctb_pkg::CTB_OFF_CODE, 32'ha5);
    apb(1'b1, ctb_pkg::CTB_OFF_CTRL, 32'h4);
    apb(1'b1, ctb_pkg::CTB_OFF_MASK, 32'h0);
    apb(1'b0, ctb_pkg::CTB_OFF_MASK, 32'h0);
    chk(rd, 32'h0f);
    hit(32'h000000a0, 1'b1);
    hit(32'h000000b5, 1'b0);
    hit(32'h123456a5, 1'b1);
    $display("filter test done");
  endtask : t_filter
  // load two buffers, lower priority value must go first
  task automatic t_tx;
    apb(1'b1, ctb_pkg::CTB_OFF_TBSEL, 32'h1);
    apb(1'b1, ctb_pkg::CTB_OFF_WIN, 32'h3c);
    apb(1'b1, 8'h7c, 32'hff);
    apb(1'b0, 8'h7c, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 8'h74, 32'h5);
    apb(1'b1, ctb_pkg::CTB_OFF_TXFLG, 32'h1);
    apb(1'b0, ctb_pkg::CTB_OFF_WIN, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, ctb_pkg::CTB_OFF_TBSEL, 32'h7);
    apb(1'b0, ctb_pkg::CTB_OFF_TBSEL, 32'h0);
    chk(rd, 32'h2);
    apb(1'b1, 8'h74, 32'h2);
    apb(1'b1, ctb_pkg::CTB_OFF_TXFLG, 32'h2);
    repeat (3) @(posedge pclk);
    chk(32'({tx_pick_valid, tx_pick, tx_pending}), 32'h2b);
    // engine read port still points at byte 0 of buffer 0
    chk(32'(eng_data), 32'h3c);
    go <= 1'b1;
    for (int i = 0; i < 100 && rd !== 32'h7; i++) apb(1'b0, ctb_pkg::CTB_OFF_TXFLG, 32'h0);
    chk(rd, 32'h7);
    apb(1'b1, ctb_pkg::CTB_OFF_TBSEL, 32'h1);
    apb(1'b0, 8'h7c, 32'h0);
    chk(32'(rd != 32'h0), 32'h1);
    $display("transmit test done");
  endtask : t_tx
  // a scheduled buffer that the engine gives up on must come back empty
  task automatic t_abort;
    go <= 1'b0;
    apb(1'b1, ctb_pkg::CTB_OFF_TBSEL, 32'h4);
    apb(1'b1, ctb_pkg::CTB_OFF_TXFLG, 32'h4);
    apb(1'b0, ctb_pkg::CTB_OFF_TXFLG, 32'h0);
    chk(rd, 32'h3);
    chk(32'(tx_pending), 32'h4);
    @(posedge pclk);
    abort_ok <= 1'b1;
    abort_idx <= 2'h2;
    @(posedge pclk);
    abort_ok <= 1'b0;
    apb(1'b0, ctb_pkg::CTB_OFF_TXFLG, 32'h0);
    chk(rd, 32'h7);
    $display("abort test done");
  endtask : t_abort
  task automatic t_init;
    apb(1'b0, ctb_pkg::CTB_OFF_TIMER, 32'h0);
    chk(32'(rd != 32'h0), 32'h1);
    apb(1'b1, ctb_pkg::CTB_OFF_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    apb(1'b0, ctb_pkg::CTB_OFF_TIMER, 32'h0);
    chk(rd, 32'h0);
    $display("init test done");
  endtask : t_init
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_filter();
    t_tx();
    t_abort();
    t_init();
    summarize();
  end
endmodule : tb
